// file: cbp_map.vh
// constants of the completion-row access block: codes, sizes, times, register map
// assumes inclusion by bare name into each design file that needs them
`ifndef CBP_MAP_VH
`define CBP_MAP_VH

// instruction register, shifted lsb first
`define CBP_IR_W 8
`define CBP_IR_ENABLE 8'hE8
`define CBP_IR_PROGRAM 8'hEA
`define CBP_IR_VERIFY 8'hEE
`define CBP_IR_DISCHARGE 8'hF0
`define CBP_IR_INIT 8'hF0
`define CBP_IR_DISABLE 8'hC0
`define CBP_IR_BYPASS 8'hFF
`define CBP_IR_CAP_LOW 2'b01

// row data register: data word above a seven-bit address
`define CBP_DATA_W 274
`define CBP_ADDR_W 7
`define CBP_DR_W 281
`define CBP_ROW_ADDR 7'h50
`define CBP_FLAG_FIRST_BIT 8
`define CBP_FLAG_SECOND_BIT 9
`define CBP_PROT_LO_BIT 1
`define CBP_PROT_HI_BIT 7

// dwell times and clock
`define CBP_CLK_MHZ 100
`define CBP_T_ENABLE_US 800
`define CBP_T_PROG_MS 10
`define CBP_T_DISCH_US 20
`define CBP_T_INIT_US 800
`define CBP_T_READ_US 20
`define CBP_US_PER_MS 1000
`define CBP_TMR_W 20

// pending operation codes
`define CBP_OP_NONE 3'h0
`define CBP_OP_ENABLE 3'h1
`define CBP_OP_PROG 3'h2
`define CBP_OP_DISCH 3'h3
`define CBP_OP_INIT 3'h4
`define CBP_OP_READ 3'h5

// avalon register map, word indices (byte address is the index times four)
`define CBP_REG_STATUS 3'h0
`define CBP_REG_CTRL 3'h1
`define CBP_REG_INSTR 3'h2
`define CBP_REG_ROW 3'h3
`define CBP_CTRL_LOCKOUT 0
`define CBP_ST_ENABLE 0
`define CBP_ST_READY 1
`define CBP_ST_BUSY 2
`define CBP_ST_CFG_OK 3
`define CBP_ST_USER 4
`define CBP_ST_READ_RDY 5
`define CBP_ST_TAP_LO 8

`endif

// file: cbp_sync.v
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk and each bit is independent
`default_nettype none
module cbp_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_b,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_r;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule
`default_nettype wire

// file: cbp_timer.v
// dwell timer: counts clk cycles while run is high, pulses done at the end
// assumes start is a one-cycle pulse; a new start restarts the count
`default_nettype none
`include "cbp_map.vh"
module cbp_timer (
   input wire clk,
   input wire rst_b,
   input wire start,
   input wire [`CBP_TMR_W-1:0] load,
   input wire run,
   output reg busy,
   output reg done
);
   reg [`CBP_TMR_W-1:0] cnt_r;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= {`CBP_TMR_W{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= load;
            busy <= 1'b1;
         end else if (busy && run) begin
            cnt_r <= cnt_r - {{(`CBP_TMR_W-1){1'b0}}, 1'b1};
            if (cnt_r <= {{(`CBP_TMR_W-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: cbp_top.v
// completion-row access: tap controller, isc instructions, the shared
// protection/completion row and an avalon-mm status/control slave
// assumes tck, tms, tdi come from an external programmer, async to ref_clk
//
// How it works
// - 8-bit instructions lsb first, loaded at update-ir
// - enable code decoded, msb set
// - enable sets flip-flop; 800 us idle dwell
// - program code selects row programming
// - 274 data bits then 7 address bits
// - completion row shares protection bits, address 1010000
// - first flag at d8 is 1, second 0
// - discharge code, 20 us idle dwell
// - init shares discharge code pattern
// - init via empty dr pass, 800 us load
// - disable ends configuration mode at idle
// - bypass all ones, then back to reset
// - after disable and reset, run user mode (entered only if init latched cfg_ok_r, i.e. the row flags were valid)
// - ir capture flushes status for checking
// - verify code selects row read
// - read-back shows completion row pattern
`default_nettype none
`include "cbp_map.vh"
module cbp_top #(
   parameter T_ENABLE_CYC = `CBP_T_ENABLE_US * `CBP_CLK_MHZ,
   parameter T_PROG_CYC = `CBP_T_PROG_MS * `CBP_US_PER_MS * `CBP_CLK_MHZ,
   parameter T_INIT_CYC = `CBP_T_INIT_US * `CBP_CLK_MHZ
) (
   input wire ref_clk,
   input wire rst_b,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo,
   output reg tdo_oe_b,
   output reg user_mode,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest
);
   localparam T_DISCH_CYC = `CBP_T_DISCH_US * `CBP_CLK_MHZ;
   localparam T_READ_CYC = `CBP_T_READ_US * `CBP_CLK_MHZ;

   localparam S_TLR = 4'h0;
   localparam S_RTI = 4'h1;
   localparam S_SEL_DR = 4'h2;
   localparam S_CAP_DR = 4'h3;
   localparam S_SH_DR = 4'h4;
   localparam S_EX1_DR = 4'h5;
   localparam S_PA_DR = 4'h6;
   localparam S_EX2_DR = 4'h7;
   localparam S_UPD_DR = 4'h8;
   localparam S_SEL_IR = 4'h9;
   localparam S_CAP_IR = 4'hA;
   localparam S_SH_IR = 4'hB;
   localparam S_EX1_IR = 4'hC;
   localparam S_PA_IR = 4'hD;
   localparam S_EX2_IR = 4'hE;
   localparam S_UPD_IR = 4'hF;

   wire [2:0] pins_s;
   reg tck_d_r;
   wire tck_s = pins_s[2];
   wire tms_s = pins_s[1];
   wire tdi_s = pins_s[0];
   wire tck_rise = tck_s & ~tck_d_r;
   wire tck_fall = ~tck_s & tck_d_r;

   reg [3:0] tap_r;
   reg [3:0] tap_nxt;
   reg [`CBP_IR_W-1:0] ir_sh_r;
   reg [`CBP_IR_W-1:0] ir_r;
   reg [`CBP_DR_W-1:0] dr_sh_r;
   reg bypass_r;
   reg [`CBP_DATA_W-1:0] nv_row_r;
   reg [`CBP_DATA_W-1:0] pend_data_r;
   reg [2:0] op_r;
   reg enable_ff_r;
   reg isc_ready_r;
   reg cfg_ok_r;
   reg read_ready_r;
   reg exit_pend_r;
   reg lockout_r;
   reg tmr_start_r;
   reg [`CBP_TMR_W-1:0] tmr_load_r;
   wire tmr_busy;
   wire tmr_done;

   wire row_dr_sel = (ir_r == `CBP_IR_PROGRAM) || (ir_r == `CBP_IR_VERIFY);
   wire addr_hit = dr_sh_r[`CBP_ADDR_W-1:0] == `CBP_ROW_ADDR;
   wire [`CBP_DATA_W-1:0] dr_data = dr_sh_r[`CBP_DR_W-1:`CBP_ADDR_W];
   wire flags_ok = nv_row_r[`CBP_FLAG_FIRST_BIT] &
      ~nv_row_r[`CBP_FLAG_SECOND_BIT];
   wire [`CBP_IR_W-1:0] ir_dec = lockout_r ? `CBP_IR_BYPASS : ir_sh_r;

   cbp_sync #(
      .W(3)
   ) u_sync (
      .clk(ref_clk),
      .rst_b(rst_b),
      .din({tck, tms, tdi}),
      .dout(pins_s)
   );

   cbp_timer u_timer (
      .clk(ref_clk),
      .rst_b(rst_b),
      .start(tmr_start_r),
      .load(tmr_load_r),
      .run(tap_r == S_RTI),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   // standard sixteen-state controller; tms high five edges always reaches reset
   always @* begin
      case (tap_r)
         S_TLR: tap_nxt = tms_s ? S_TLR : S_RTI;
         S_RTI: tap_nxt = tms_s ? S_SEL_DR : S_RTI;
         S_SEL_DR: tap_nxt = tms_s ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: tap_nxt = tms_s ? S_EX1_DR : S_SH_DR;
         S_SH_DR: tap_nxt = tms_s ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: tap_nxt = tms_s ? S_UPD_DR : S_PA_DR;
         S_PA_DR: tap_nxt = tms_s ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: tap_nxt = tms_s ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: tap_nxt = tms_s ? S_SEL_DR : S_RTI;
         S_SEL_IR: tap_nxt = tms_s ? S_TLR : S_CAP_IR;
         S_CAP_IR: tap_nxt = tms_s ? S_EX1_IR : S_SH_IR;
         S_SH_IR: tap_nxt = tms_s ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: tap_nxt = tms_s ? S_UPD_IR : S_PA_IR;
         S_PA_IR: tap_nxt = tms_s ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: tap_nxt = tms_s ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: tap_nxt = tms_s ? S_SEL_DR : S_RTI;
         default: tap_nxt = S_TLR;
      endcase
   end

   // tap state and shift paths on tck rising edges
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tck_d_r <= 1'b0;
         tap_r <= S_TLR;
         ir_sh_r <= `CBP_IR_BYPASS;
         dr_sh_r <= {`CBP_DR_W{1'b0}};
         bypass_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
         if (tck_rise) begin
            tap_r <= tap_nxt;
            case (tap_r)
               S_CAP_IR:
                  // status flushed out as each instruction is shifted in
                  ir_sh_r <= {3'b000, user_mode, enable_ff_r, flags_ok,
                     `CBP_IR_CAP_LOW};
               S_SH_IR:
                  ir_sh_r <= {tdi_s, ir_sh_r[`CBP_IR_W-1:1]};
               S_CAP_DR: begin
                  bypass_r <= 1'b0;
                  if (ir_r == `CBP_IR_VERIFY && read_ready_r)
                     dr_sh_r <= {nv_row_r, {`CBP_ADDR_W{1'b0}}};
               end
               S_SH_DR: begin
                  // data msb first, then address; last bit lands in address bit 0
                  if (row_dr_sel)
                     dr_sh_r <= {dr_sh_r[`CBP_DR_W-2:0], tdi_s};
                  else
                     bypass_r <= tdi_s;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // tdo changes on the falling tck edge, driven only while shifting
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tdo <= 1'b1;
         tdo_oe_b <= 1'b1;
      end else if (tck_fall) begin
         tdo_oe_b <= ~(tap_r == S_SH_IR || tap_r == S_SH_DR);
         if (tap_r == S_SH_IR)
            tdo <= ir_sh_r[0];
         else if (tap_r == S_SH_DR)
            tdo <= row_dr_sel ? dr_sh_r[`CBP_DR_W-1] : bypass_r;
         else
            tdo <= 1'b1;
      end
   end

   // isc instruction and operation control: updates act on falling tck edges, disable and reset entry on rising edges
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_r <= `CBP_IR_BYPASS;
         op_r <= `CBP_OP_NONE;
         enable_ff_r <= 1'b0;
         isc_ready_r <= 1'b0;
         cfg_ok_r <= 1'b0;
         read_ready_r <= 1'b0;
         exit_pend_r <= 1'b0;
         user_mode <= 1'b0;
         tmr_start_r <= 1'b0;
         tmr_load_r <= {`CBP_TMR_W{1'b0}};
         nv_row_r <= {`CBP_DATA_W{1'b1}};
         pend_data_r <= {`CBP_DATA_W{1'b1}};
      end else begin
         tmr_start_r <= 1'b0;
         if (tck_fall && tap_r == S_UPD_IR) begin
            ir_r <= ir_dec;
            if (ir_dec == `CBP_IR_ENABLE) begin
               enable_ff_r <= 1'b1;
               isc_ready_r <= 1'b0;
               user_mode <= 1'b0;
               op_r <= `CBP_OP_ENABLE;
               tmr_load_r <= T_ENABLE_CYC[`CBP_TMR_W-1:0];
               tmr_start_r <= 1'b1;
            end else if (ir_dec == `CBP_IR_DISCHARGE && enable_ff_r) begin
               // the same code becomes init once a dr update follows
               op_r <= `CBP_OP_DISCH;
               tmr_load_r <= T_DISCH_CYC[`CBP_TMR_W-1:0];
               tmr_start_r <= 1'b1;
            end
         end
         if (tck_fall && tap_r == S_UPD_DR && enable_ff_r) begin
            if (ir_r == `CBP_IR_PROGRAM && addr_hit) begin
               // whole shared row is rewritten, protection bits included
               pend_data_r <= dr_data;
               op_r <= `CBP_OP_PROG;
               tmr_load_r <= T_PROG_CYC[`CBP_TMR_W-1:0];
               tmr_start_r <= 1'b1;
            end else if (ir_r == `CBP_IR_VERIFY) begin
               read_ready_r <= 1'b0;
               if (addr_hit) begin
                  op_r <= `CBP_OP_READ;
                  tmr_load_r <= T_READ_CYC[`CBP_TMR_W-1:0];
                  tmr_start_r <= 1'b1;
               end
            end else if (ir_r == `CBP_IR_INIT) begin
               op_r <= `CBP_OP_INIT;
               tmr_load_r <= T_INIT_CYC[`CBP_TMR_W-1:0];
               tmr_start_r <= 1'b1;
            end
         end
         if (tmr_done) begin
            op_r <= `CBP_OP_NONE;
            case (op_r)
               `CBP_OP_ENABLE: isc_ready_r <= 1'b1;
               // programming can only clear erased cells
               `CBP_OP_PROG: nv_row_r <= nv_row_r & pend_data_r;
               `CBP_OP_INIT: cfg_ok_r <= flags_ok;
               `CBP_OP_READ: read_ready_r <= 1'b1;
               default: begin
               end
            endcase
         end
         if (tck_rise && tap_nxt == S_RTI && tap_r != S_RTI &&
               ir_r == `CBP_IR_DISABLE && enable_ff_r) begin
            enable_ff_r <= 1'b0;
            isc_ready_r <= 1'b0;
            exit_pend_r <= 1'b1;
         end
         if (tck_rise && tap_nxt == S_TLR && tap_r != S_TLR) begin
            ir_r <= `CBP_IR_BYPASS;
            if (exit_pend_r) begin
               exit_pend_r <= 1'b0;
               user_mode <= cfg_ok_r;
            end
         end
      end
   end

   // avalon slave: one wait cycle, then answer with waitrequest low
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         lockout_r <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h00000000;
            if (avs_read && avs_address[1:0] == 2'b00) begin
               case (avs_address[4:2])
                  `CBP_REG_STATUS: begin
                     avs_readdata[`CBP_ST_ENABLE] <= enable_ff_r;
                     avs_readdata[`CBP_ST_READY] <= isc_ready_r;
                     avs_readdata[`CBP_ST_BUSY] <= tmr_busy;
                     avs_readdata[`CBP_ST_CFG_OK] <= cfg_ok_r;
                     avs_readdata[`CBP_ST_USER] <= user_mode;
                     avs_readdata[`CBP_ST_READ_RDY] <= read_ready_r;
                     avs_readdata[`CBP_ST_TAP_LO+3:`CBP_ST_TAP_LO] <= tap_r;
                  end
                  `CBP_REG_CTRL: avs_readdata[`CBP_CTRL_LOCKOUT] <= lockout_r;
                  `CBP_REG_INSTR: avs_readdata[`CBP_IR_W-1:0] <= ir_r;
                  `CBP_REG_ROW: avs_readdata <= nv_row_r[31:0];
                  default: avs_readdata <= 32'h00000000;
               endcase
            end
         end
         if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
               avs_address == {`CBP_REG_CTRL, 2'b00})
            lockout_r <= avs_writedata[`CBP_CTRL_LOCKOUT];
      end
   end
endmodule
`default_nettype wire

// file: cbp_chk_asserts.sv
// checker: avalon handshake and tap pin timing of cbp_top
// assumes bind onto cbp_top, one ref_clk domain
`default_nettype none
`include "cbp_map.vh"
module cbp_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdo_oe_b,
   input wire logic user_mode,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic req = avs_read | avs_write;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   a_answer_next: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   a_no_stray: assert property (!req |=> avs_waitrequest)
      else $error("answer without request");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
      (avs_address[1:0] != 2'b00 || avs_address > 5'h0C) |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_user: assert property (avs_read && avs_waitrequest && avs_address == 5'h00
      |=> avs_readdata[`CBP_ST_USER] == $past(user_mode) && avs_readdata[31:12] == 20'h0)
      else $error("status word wrong");
   a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("read data moved");
   a_reset_vals: assert property ($rose(rst_b) |-> tdo && tdo_oe_b && !user_mode &&
      avs_waitrequest && avs_readdata == 32'h0)
      else $error("bad value after reset");
   a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck))
      else $error("tdo moved while tck high");
   a_tdo_release: assert property ($rose(tdo_oe_b) |-> ##[0:16] tdo)
      else $error("released tdo not high");
   a_user_tlr: assert property ($rose(user_mode) |-> $past(tms, 2) && tdo_oe_b)
      else $error("user mode outside reset entry");
endmodule
`default_nettype wire

// file: cbp_prog_model.sv
// programmer model: drives tck, tms and tdi, shifts ir and dr words
// assumes tdo_w is the resolved tdo line, high when released
`default_nettype none
module cbp_prog_model (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input wire logic tdo_w
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 160 ns period; tck rests low between frames
   // pins change by nba so a coinciding ref_clk edge still samples the old level
   task automatic clk1(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      #80 tck <= 1'b1;
      o = tdo_w;
      #80 tck <= 1'b0;
   endtask
   // tms path lsb first, tdi toggling when it carries no data
   task automatic walk(input logic [7:0] p, input int n);
      logic o;
      for (int i = 0; i < n; i++) clk1((i < 8) ? p[i] : 1'b0, ~tdi, o);
   endtask
   task automatic reset5();
      walk(8'h1F, 6);
   endtask
   task automatic ir(input logic [7:0] c, output logic [7:0] cap);
      walk(8'h03, 4);
      for (int i = 0; i < 8; i++) clk1(i == 7, c[i], cap[i]);
      walk(8'h01, 2);
   endtask
   task automatic dr(input logic [280:0] v, input int n, output logic [280:0] q);
      q = '0;
      walk(8'h01, 3);
      for (int i = n - 1; i >= 0; i--) clk1(i == 0, v[i], q[i]);
      walk(8'h01, 2);
   endtask
   task automatic dr_empty();
      walk(8'h0D, 5);
   endtask
   task automatic to_tlr();
      walk(8'h07, 3);
   endtask
endmodule
`default_nettype wire

// file: tb.sv
// top bench: register checks, then program and read-back of the flag row
// assumes cbp_prog_model drives the tap pins; tdo pulled high when released
`default_nettype none
`include "cbp_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 16;
   localparam int T_EN = 50;
   localparam int T_PG = 200;
   localparam int T_IN = 50;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   wire logic tck, tms, tdi, tdo, tdo_oe_b, user_mode, avs_waitrequest;
   wire logic [31:0] avs_readdata;
   wire logic tdo_w = tdo_oe_b ? 1'b1 : tdo;
   wire logic [273:0] row_full = ~(274'h1 << 9);
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] rd, wd;
   logic [7:0] cap;
   logic [280:0] q;
   logic [287:0] big;
   logic [6:0] bad_addr;
   logic [4:0] ra;
   logic [3:0] rbe;
   logic lk = 1'b0;

   always #5 ref_clk = ~ref_clk;

   cbp_top #(.T_ENABLE_CYC(T_EN), .T_PROG_CYC(T_PG), .T_INIT_CYC(T_IN)) uut (
      .ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_b(tdo_oe_b), .user_mode(user_mode), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   cbp_prog_model prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w));

   task automatic chk(input logic [280:0] got, input logic [280:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      if (k >= 20) bad_count++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   function automatic logic [31:0] exp_rd(input logic [4:0] a, input logic l);
      case (a)
         5'h04: return {31'h0, l};
         5'h08: return {24'h0, `CBP_IR_BYPASS};
         5'h0C: return 32'hFFFFFFFF;
         default: return 32'h0;
      endcase
   endfunction
   task automatic tail(input logic ok);
      prog.ir(`CBP_IR_DISCHARGE, cap);
      prog.walk(8'h00, 2000 / TC + 2);
      prog.ir(`CBP_IR_INIT, cap);
      prog.dr_empty();
      prog.walk(8'h00, T_IN / TC + 2);
      av(1'b0, 5'h00, 32'h0);
      chk(rd[`CBP_ST_CFG_OK], ok);
      prog.ir(`CBP_IR_DISABLE, cap);
      prog.walk(8'h00, 2);
      av(1'b0, 5'h00, 32'h0);
      chk(rd[`CBP_ST_ENABLE], 1'b0);
      prog.ir(`CBP_IR_BYPASS, cap);
      prog.to_tlr();
      repeat (8) @(posedge ref_clk);
      chk(user_mode, ok);
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      void'($urandom(10952));
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      av(1'b0, 5'h00, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 24; i++) begin
         ra = (i == 0) ? 5'h10 : (i == 1) ? 5'h05 : (i == 2) ? 5'h04 : 5'($urandom);
         rbe = 4'($urandom);
         wd = $urandom;
         avs_byteenable <= rbe;
         av(1'b1, ra, wd);
         if (ra == 5'h04 && rbe[0]) lk = wd[0];
         av(1'b0, ra, 32'h0);
         chk(rd, exp_rd(ra, lk));
      end
      avs_byteenable <= 4'hF;
      av(1'b1, 5'h04, 32'h1);
      prog.reset5();
      av(1'b0, 5'h00, 32'h0);
      chk(rd[11:8], 4'h1);
      prog.ir(`CBP_IR_BYPASS, cap);
      chk(cap, 8'h01);
      prog.ir(`CBP_IR_ENABLE, cap);
      av(1'b0, 5'h08, 32'h0);
      chk(rd, {24'h0, `CBP_IR_BYPASS});
      av(1'b1, 5'h04, 32'h0);
      prog.ir(`CBP_IR_ENABLE, cap);
      prog.walk(8'h00, T_EN / TC + 2);
      tail(1'b0);
      prog.reset5();
      prog.ir(`CBP_IR_ENABLE, cap);
      av(1'b0, 5'h08, 32'h0);
      chk(rd, {24'h0, `CBP_IR_ENABLE});
      av(1'b0, 5'h00, 32'h0);
      chk(rd[`CBP_ST_ENABLE], 1'b1);
      prog.walk(8'h00, T_EN / TC + 2);
      av(1'b0, 5'h00, 32'h0);
      chk(rd[`CBP_ST_READY], 1'b1);
      prog.ir(`CBP_IR_PROGRAM, cap);
      big = {9{$urandom}};
      bad_addr = 7'($urandom);
      if (bad_addr == `CBP_ROW_ADDR) bad_addr = 7'h51;
      prog.dr({big[273:0], bad_addr}, 281, q);
      prog.walk(8'h00, T_PG / TC + 2);
      av(1'b0, 5'h0C, 32'h0);
      chk(rd, 32'hFFFFFFFF);
      prog.dr({row_full, `CBP_ROW_ADDR}, 281, q);
      prog.walk(8'h00, 1);
      av(1'b0, 5'h00, 32'h0);
      chk(rd[`CBP_ST_BUSY], 1'b1);
      prog.walk(8'h00, T_PG / TC + 2);
      av(1'b0, 5'h0C, 32'h0);
      chk(rd, row_full[31:0]);
      tail(1'b1);
      prog.reset5();
      prog.ir(`CBP_IR_BYPASS, cap);
      chk(cap, 8'h15);
      prog.ir(`CBP_IR_ENABLE, cap);
      chk(user_mode, 1'b0);
      prog.walk(8'h00, T_EN / TC + 2);
      prog.ir(`CBP_IR_VERIFY, cap);
      prog.dr({274'h0, `CBP_ROW_ADDR}, 281, q);
      prog.walk(8'h00, 2000 / TC + 2);
      prog.dr({281{1'b1}}, 281, q);
      chk(q[280:7], row_full);
      tail(1'b1);
      conclude();
   end
endmodule
bind cbp_top cbp_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms),
   .tdo(tdo), .tdo_oe_b(tdo_oe_b), .user_mode(user_mode), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));
`default_nettype wire
